// >>> hw/xps_pkg.sv
// constants shared by both ends of the peripheral setup register link
// assumes: 16-bit sfr words, 24-bit internal peripheral bus addresses
package xps_pkg;
  localparam int SFR_W      = 16;
  localparam int ACC_ADDR_W = 24;
  localparam int NUM_PERIPH = 3;
  localparam int CLK_BITS   = 15;
  localparam int WAIT_W     = 4;
  localparam int WIN_W      = 12;
  localparam int SIZE_W     = 4;

  // register offsets on the sfr link
  localparam logic [15:0] OFS_USB_WIN  = 16'hf016;
  localparam logic [15:0] OFS_EVT_WIN  = 16'hf018;
  localparam logic [15:0] OFS_PER_EN   = 16'hf024;
  localparam logic [15:0] OFS_CFG0     = 16'hf114;
  localparam logic [15:0] OFS_USB_CFG  = 16'hf116;
  localparam logic [15:0] OFS_EVT_CFG  = 16'hf118;
  localparam logic [15:0] OFS_CLK_GATE = 16'hf1d4;
  localparam logic [15:0] OFS_SYS_CFG  = 16'hff12;

  // reset values
  localparam logic [15:0] RST_ZERO = 16'h0000;

  // periph_enable fields
  localparam int PEN_USB = 6;
  localparam int PEN_EVT = 7;
  // system_config fields
  localparam int SYS_MIRROR = 1;
  localparam int SYS_PER_EN = 2;
  // clock_gating fields
  localparam int CG_ALL_OFF = 15;
  localparam int CG_XCVR_HI = 12;
  localparam int CG_XCVR_LO = 11;
  localparam int CG_EVT     = 8;
  localparam int CG_USB     = 7;
  localparam int CG_TMR     = 3;
  localparam int CG_SSP     = 2;
  localparam int CG_ASP     = 1;
  localparam int CG_RTC     = 0;
  localparam logic [1:0] XCVR_NORMAL  = 2'h0;
  localparam logic [1:0] XCVR_SUSPEND = 2'h1;
  localparam logic [1:0] XCVR_RSVD    = 2'h2;
  localparam logic [1:0] XCVR_OFF     = 2'h3;

  // bus-configuration fields
  localparam int BCFG_EN   = 10;
  localparam int BCFG_WIDE = 7;
  localparam int BCFG_MUX  = 6;
  localparam int BCFG_WS_LO = 0;
  // address-window fields: base in 15:4, ignored low base bits in 3:0
  localparam int WIN_BASE_LO = 4;
  localparam int WIN_SIZE_LO = 0;

  // slot order on the internal peripheral bus
  localparam int SLOT_UNUSED = 0;
  localparam int SLOT_USB    = 1;
  localparam int SLOT_EVT    = 2;

  // recommended init values
  localparam logic [15:0] INIT_CFG0    = 16'h0000;
  localparam logic [15:0] INIT_USB_WIN = 16'h0ee0;
  localparam logic [15:0] INIT_EVT_WIN = 16'h0ed0;
  localparam logic [15:0] INIT_CFG_0WS = 16'h048f;
  localparam int          INIT_STEPS   = 5;

  // controller apb map
  localparam logic [11:0] APB_CMD    = 12'h000;
  localparam logic [11:0] APB_ADDR   = 12'h004;
  localparam logic [11:0] APB_WDATA  = 12'h008;
  localparam logic [11:0] APB_RDATA  = 12'h00c;
  localparam logic [11:0] APB_STATUS = 12'h010;
  localparam int CMD_GO    = 0;
  localparam int CMD_WRITE = 1;
  localparam int CMD_INIT  = 2;
  localparam int STS_BUSY  = 0;
  localparam int STS_DONE  = 1;

  typedef enum logic [2:0] {
    XPS_IDLE = 3'b001,
    XPS_REQ  = 3'b010,
    XPS_NEXT = 3'b100
  } xps_state_t;
endpackage : xps_pkg

// >>> hw/xps_sfr_if.sv
// sfr link between the setup controller and the setup register bank
// assumes: both ends clocked by the same pclk
`timescale 1ns/1ns
interface xps_sfr_if;
  logic        req;
  logic        we;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        ack;

  modport dev (input req, input we, input addr, input wdata, output rdata, output ack);
  modport ctl (output req, output we, output addr, output wdata, input rdata, input ack);
endinterface : xps_sfr_if

// >>> hw/xps_dev.sv
// setup register bank for the internal peripheral bus, with window decode
// assumes: controller holds req until ack; access inputs come from pclk logic
//
// Behaviour
// R1: peripheral bus copies external bus cycle options
// R2: at most three peripheral slots
// R3: each slot windowed by config plus window register; slot 0 uses the SLOT0_WIN parameter instead of a register
// R4: slot pairs fixed by build, not relocatable
// R5: byte or word, muxed or demuxed accesses
// R6: periph_enable bit6 switches usb module
// R7: periph_enable bit7 switches event controller
// R8: system_config bit2 enables all peripherals
// R9: system_config bit1 mirrors accesses on pins
// R10: clock_gating bit15 stops every peripheral clock
// R11: clock_gating low bits stop single clocks
// R12: transceiver code in bits 12:11, 10 reserved
// R13: transceiver code leaves usb module alone
// R14: software keeps first bus config zero
// R15: software sets usb config to 048x
// R16: software sets event config to 048x
// R17: usb window 0ee0 before usb config
// R18: event window 0ed0 before event config
// R19: external selects high during internal access
// R20: registers load defaults on reset
`timescale 1ns/1ns
module xps_dev
  import xps_pkg::*;
#(
  parameter int          ADDR_W    = xps_pkg::ACC_ADDR_W,
  parameter logic [15:0] SLOT0_WIN = 16'h0000
) (
  // clock and reset
  input  wire logic                          pclk,
  input  wire logic                          presetn,
  // register link
  xps_sfr_if.dev                             sfr,
  // access from the bus controller
  input  wire logic                          acc_valid,
  input  wire logic                          acc_write,
  input  wire logic [ADDR_W-1:0]             acc_addr,
  // internal peripheral bus control
  output logic      [xps_pkg::NUM_PERIPH-1:0] int_cs,
  output logic                               ext_cs_high,
  output logic                               ext_mirror,
  output logic                               acc_wr_out,
  output logic                               acc_wide,
  output logic                               acc_demux,
  output logic      [xps_pkg::WAIT_W-1:0]    acc_wait,
  // peripheral control
  output logic                               usb_enable,
  output logic                               evt_enable,
  output logic      [xps_pkg::CLK_BITS-1:0]  clk_off,
  output logic      [1:0]                    xcvr_state
);
  import xps_pkg::*;

  logic [15:0] bcfg [NUM_PERIPH];
  logic [15:0] usb_win;
  logic [15:0] evt_win;
  logic [15:0] per_en;
  logic [15:0] gate;
  logic [15:0] sys_cfg;
  logic        take;
  logic [NUM_PERIPH-1:0] hit;
  logic [NUM_PERIPH-1:0] next_cs;
  logic [15:0] sel_cfg;

  assign take = sfr.req && !sfr.ack;

  // window match: base bits above the size code must agree
  function automatic logic win_hit(input logic [ADDR_W-1:0] a, input logic [15:0] w);
    logic [WIN_W-1:0] mask;
    mask = {WIN_W{1'b1}} << w[WIN_SIZE_LO +: SIZE_W];
    win_hit = ((a[ADDR_W-1 -: WIN_W] ^ w[WIN_BASE_LO +: WIN_W]) & mask) == '0;
  endfunction : win_hit

  // reserved transceiver code keeps the old field
  function automatic logic [15:0] gate_wr(input logic [15:0] old, input logic [15:0] nw);
    gate_wr = nw;
    if (nw[CG_XCVR_HI:CG_XCVR_LO] == XCVR_RSVD) begin // [R12]
      gate_wr[CG_XCVR_HI:CG_XCVR_LO] = old[CG_XCVR_HI:CG_XCVR_LO];
    end
  endfunction : gate_wr

  // slot hit: config enabled, slot switched on, address inside its window
  function automatic logic slot_hit(input logic [15:0] cfg, input logic on,
                                    input logic [ADDR_W-1:0] a, input logic [15:0] w);
    slot_hit = cfg[BCFG_EN] && on && win_hit(a, w);
  endfunction : slot_hit

  // a clock stops on its own bit or on the global stop
  function automatic logic clk_stop(input logic [15:0] g, input int idx);
    clk_stop = g[CG_ALL_OFF] || g[idx];
  endfunction : clk_stop

  // register writes, taken once per request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin // [R20]
      for (int i = 0; i < NUM_PERIPH; i++) begin
        bcfg[i] <= RST_ZERO;
      end
      usb_win <= RST_ZERO;
      evt_win <= RST_ZERO;
      per_en  <= RST_ZERO;
      gate    <= RST_ZERO;
      sys_cfg <= RST_ZERO;
    end else if (take && sfr.we) begin
      case (sfr.addr)
        OFS_USB_WIN:  usb_win <= sfr.wdata;
        OFS_EVT_WIN:  evt_win <= sfr.wdata;
        OFS_PER_EN:   per_en <= sfr.wdata;
        OFS_CFG0:     bcfg[SLOT_UNUSED] <= sfr.wdata;
        OFS_USB_CFG:  bcfg[SLOT_USB] <= sfr.wdata;
        OFS_EVT_CFG:  bcfg[SLOT_EVT] <= sfr.wdata;
        OFS_CLK_GATE: gate <= gate_wr(gate, sfr.wdata);
        OFS_SYS_CFG:  sys_cfg <= sfr.wdata;
        default: ;
      endcase
    end
  end

  // answer: ack one cycle after the request, read data with it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sfr.ack   <= 1'b0;
      sfr.rdata <= RST_ZERO;
    end else begin
      sfr.ack <= take;
      if (take && !sfr.we) begin
        case (sfr.addr)
          OFS_USB_WIN:  sfr.rdata <= usb_win;
          OFS_EVT_WIN:  sfr.rdata <= evt_win;
          OFS_PER_EN:   sfr.rdata <= per_en;
          OFS_CFG0:     sfr.rdata <= bcfg[SLOT_UNUSED];
          OFS_USB_CFG:  sfr.rdata <= bcfg[SLOT_USB];
          OFS_EVT_CFG:  sfr.rdata <= bcfg[SLOT_EVT];
          OFS_CLK_GATE: sfr.rdata <= gate;
          OFS_SYS_CFG:  sfr.rdata <= sys_cfg;
          default:      sfr.rdata <= RST_ZERO;
        endcase
      end
    end
  end

  // slot decode, lowest slot wins on overlap
  always_comb begin
    hit     = '0;
    next_cs = '0;
    sel_cfg = RST_ZERO;
    // three fixed slots, each a config plus window pair
    hit[SLOT_UNUSED] = slot_hit(bcfg[SLOT_UNUSED], 1'b1, acc_addr, SLOT0_WIN); // [R2] [R4]
    hit[SLOT_USB]    = slot_hit(bcfg[SLOT_USB], per_en[PEN_USB], acc_addr, usb_win); // [R3]
    hit[SLOT_EVT]    = slot_hit(bcfg[SLOT_EVT], per_en[PEN_EVT], acc_addr, evt_win); // [R3]
    if (acc_valid && sys_cfg[SYS_PER_EN]) begin // [R8]
      for (int i = NUM_PERIPH - 1; i >= 0; i--) begin
        if (hit[i]) begin
          next_cs    = '0;
          next_cs[i] = 1'b1;
          sel_cfg    = bcfg[i];
        end
      end
    end
  end

  // registered bus cycle attributes, same options as external cycles
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_cs      <= '0;
      ext_cs_high <= 1'b0;
      ext_mirror  <= 1'b0;
      acc_wr_out  <= 1'b0;
      acc_wide    <= 1'b0;
      acc_demux   <= 1'b0;
      acc_wait    <= '0;
    end else begin
      int_cs      <= next_cs; // [R1]
      ext_cs_high <= |next_cs; // [R19]
      ext_mirror  <= (|next_cs) && sys_cfg[SYS_MIRROR]; // [R9]
      acc_wr_out  <= (|next_cs) && acc_write;
      acc_wide    <= sel_cfg[BCFG_WIDE]; // [R5]
      acc_demux   <= !sel_cfg[BCFG_MUX]; // [R5]
      acc_wait    <= ~sel_cfg[BCFG_WS_LO +: WAIT_W]; // [R1]
    end
  end

  // peripheral enables and clock stops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_enable <= 1'b0;
      evt_enable <= 1'b0;
      clk_off    <= '0;
      xcvr_state <= XCVR_NORMAL;
    end else begin
      usb_enable <= sys_cfg[SYS_PER_EN] && per_en[PEN_USB]; // [R6] [R8] [R13]
      evt_enable <= sys_cfg[SYS_PER_EN] && per_en[PEN_EVT]; // [R7] [R8]
      // unused clock bits stay low
      clk_off    <= '0;
      clk_off[CG_EVT] <= clk_stop(gate, CG_EVT); // [R10] [R11]
      clk_off[CG_USB] <= clk_stop(gate, CG_USB); // [R10] [R11]
      clk_off[CG_TMR] <= clk_stop(gate, CG_TMR); // [R10] [R11]
      clk_off[CG_SSP] <= clk_stop(gate, CG_SSP); // [R10] [R11]
      clk_off[CG_ASP] <= clk_stop(gate, CG_ASP); // [R10] [R11]
      clk_off[CG_RTC] <= clk_stop(gate, CG_RTC); // [R10] [R11]
      xcvr_state <= gate[CG_XCVR_HI:CG_XCVR_LO]; // [R12] [R13]
    end
  end
endmodule : xps_dev

// >>> hw/xps_ctl.sv
// setup controller: apb slave for software, master of the sfr link
// assumes: apb master on pclk; register bank acks each request
`timescale 1ns/1ns
module xps_ctl
  import xps_pkg::*;
(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // register link
  xps_sfr_if.ctl           sfr
);
  import xps_pkg::*;

  xps_state_t  state;
  logic [15:0] cmd_addr;
  logic [15:0] cmd_wdata;
  logic [15:0] rd_result;
  logic        busy;
  logic        done;
  logic        init_mode;
  logic [2:0]  step;
  logic        apb_wr;
  logic        go;
  logic        finish;

  // recommended init order: window before its config
  function automatic logic [31:0] init_op(input logic [2:0] idx);
    case (idx)
      3'h0:    init_op = {OFS_CFG0, INIT_CFG0}; // [R14]
      3'h1:    init_op = {OFS_USB_WIN, INIT_USB_WIN}; // [R17]
      3'h2:    init_op = {OFS_USB_CFG, INIT_CFG_0WS}; // [R15]
      3'h3:    init_op = {OFS_EVT_WIN, INIT_EVT_WIN}; // [R18]
      default: init_op = {OFS_EVT_CFG, INIT_CFG_0WS}; // [R16]
    endcase
  endfunction : init_op

  assign apb_wr = psel && penable && pready && pwrite;
  assign go     = apb_wr && paddr == APB_CMD && !busy
                  && (pwdata[CMD_GO] || pwdata[CMD_INIT]);
  assign finish = state == XPS_REQ && sfr.ack
                  && (!init_mode || step == 3'(INIT_STEPS - 1));

  // apb answer: pready one cycle into the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && penable && !pready;
      if (psel && penable && !pready && !pwrite) begin
        case (paddr)
          APB_CMD:    prdata <= '0;
          APB_ADDR:   prdata <= {16'h0000, cmd_addr};
          APB_WDATA:  prdata <= {16'h0000, cmd_wdata};
          APB_RDATA:  prdata <= {16'h0000, rd_result};
          APB_STATUS: prdata <= {30'h0000_0000, done, busy};
          default:    prdata <= '0;
        endcase
      end
    end
  end

  // software-loaded address and data, frozen while busy
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cmd_addr  <= RST_ZERO;
      cmd_wdata <= RST_ZERO;
    end else if (apb_wr && !busy) begin
      if (paddr == APB_ADDR) begin
        cmd_addr <= pwdata[15:0];
      end
      if (paddr == APB_WDATA) begin
        cmd_wdata <= pwdata[15:0];
      end
    end
  end

  // done: set on finish, cleared by writing one, set wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done <= 1'b0;
    end else if (finish) begin
      done <= 1'b1;
    end else if (apb_wr && paddr == APB_STATUS && pwdata[STS_DONE]) begin
      done <= 1'b0;
    end
  end

  // link sequencer: single access or init sequence
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state     <= XPS_IDLE;
      busy      <= 1'b0;
      init_mode <= 1'b0;
      step      <= '0;
      rd_result <= RST_ZERO;
      sfr.req   <= 1'b0;
      sfr.we    <= 1'b0;
      sfr.addr  <= RST_ZERO;
      sfr.wdata <= RST_ZERO;
    end else begin
      case (state)
        XPS_IDLE: begin
          if (go) begin
            busy    <= 1'b1;
            sfr.req <= 1'b1;
            step    <= '0;
            if (pwdata[CMD_INIT]) begin
              init_mode <= 1'b1;
              sfr.we    <= 1'b1;
              {sfr.addr, sfr.wdata} <= init_op(3'h0);
            end else begin
              init_mode <= 1'b0;
              sfr.we    <= pwdata[CMD_WRITE];
              sfr.addr  <= cmd_addr;
              sfr.wdata <= cmd_wdata;
            end
            state <= XPS_REQ;
          end
        end
        XPS_REQ: begin
          if (sfr.ack) begin
            sfr.req <= 1'b0;
            if (!sfr.we) begin
              rd_result <= sfr.rdata;
            end
            if (finish) begin
              busy  <= 1'b0;
              state <= XPS_IDLE;
            end else begin
              step  <= step + 3'h1;
              state <= XPS_NEXT;
            end
          end
        end
        XPS_NEXT: begin
          sfr.req <= 1'b1;
          {sfr.addr, sfr.wdata} <= init_op(step);
          state <= XPS_REQ;
        end
        default: state <= XPS_IDLE;
      endcase
    end
  end
endmodule : xps_ctl

// >>> bench/xps_checker.sv
// checker for the sfr link between setup controller and register bank
// assumes: one pclk domain, instantiated beside the link in the bench
`timescale 1ns/1ns
module xps_checker
  import xps_pkg::*;
(
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // link signals
  input wire logic        req,
  input wire logic        we,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        ack
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [15:0] cg;
  logic        usb_win_set;
  logic        evt_win_set;
  logic        rd_ack;
  logic        mapped;

  assign rd_ack = ack && !we;
  assign mapped = addr inside {OFS_USB_WIN, OFS_EVT_WIN, OFS_PER_EN, OFS_CFG0,
                               OFS_USB_CFG, OFS_EVT_CFG, OFS_CLK_GATE, OFS_SYS_CFG};

  // expected clock_gating content, reserved code keeps old field
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cg <= RST_ZERO;
    end else if (ack && we && addr == OFS_CLK_GATE) begin
      cg <= (wdata[12:11] == XCVR_RSVD) ? {wdata[15:13], cg[12:11], wdata[10:0]} : wdata;
    end
  end

  // windows seen written before their bus configs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      usb_win_set <= 1'b0;
      evt_win_set <= 1'b0;
    end else if (ack && we) begin
      usb_win_set <= usb_win_set || addr == OFS_USB_WIN;
      evt_win_set <= evt_win_set || addr == OFS_EVT_WIN;
    end
  end

  sequence s_taken;
    req && !ack;
  endsequence
  sequence s_answer;
    ack ##1 !ack;
  endsequence

  property p_answer;
    s_taken |=> s_answer;
  endproperty
  property p_hold;
    s_taken |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  property p_release;
    ack |=> !req;
  endproperty
  property p_no_spurious;
    ack |-> $past(req) && !$past(ack);
  endproperty
  property p_cg_read;
    rd_ack && addr == OFS_CLK_GATE |-> rdata == cg;
  endproperty
  property p_unmapped;
    rd_ack && !mapped |-> rdata == 16'h0000;
  endproperty
  property p_rdata_hold;
    !rd_ack |-> $stable(rdata);
  endproperty
  property p_usb_order;
    ack && we && addr == OFS_USB_CFG |-> usb_win_set;
  endproperty
  property p_evt_order;
    ack && we && addr == OFS_EVT_CFG |-> evt_win_set;
  endproperty

  a_answer: assert property (p_answer) else $error("ack not one cycle after request");
  a_hold: assert property (p_hold) else $error("request changed before ack");
  a_release: assert property (p_release) else $error("request kept after ack");
  a_no_spurious: assert property (p_no_spurious) else $error("ack without request");
  a_cg_read: assert property (p_cg_read) else $error("clock gating read wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");
  a_usb_order: assert property (p_usb_order) else $error("usb config before window");
  a_evt_order: assert property (p_evt_order) else $error("event config before window");
endmodule : xps_checker

// >>> bench/internal_periph_bus_periph_setup_regs_bench.sv
// bench: setup controller and register bank joined by the sfr link
// assumes: software side over apb, access decode driven directly
`timescale 1ns/1ns
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
  $display("Error %0t: got %h expected %h", $time, a, b); end end
module internal_periph_bus_periph_setup_regs_bench;
  import xps_pkg::*;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        acc_valid;
  logic        acc_write;
  logic [8:0]  att;
  logic [23:0] acc_addr;
  logic [2:0]  int_cs;
  logic        ext_cs_high;
  logic        ext_mirror;
  logic        acc_wr_out;
  logic        acc_wide;
  logic        acc_demux;
  logic [3:0]  acc_wait;
  logic        usb_enable;
  logic        evt_enable;
  logic [14:0] clk_off;
  logic [1:0]  xcvr_state;
  logic [15:0] rd;
  int          mismatches;
  int          n_compared;
  int          cycles;
  logic [15:0] ofs[9] = '{OFS_USB_WIN, OFS_EVT_WIN, OFS_PER_EN, OFS_CFG0, OFS_USB_CFG,
                          OFS_EVT_CFG, OFS_CLK_GATE, OFS_SYS_CFG, 16'hf000};
  logic [15:0] ini_a[5] = '{OFS_CFG0, OFS_USB_WIN, OFS_USB_CFG, OFS_EVT_WIN, OFS_EVT_CFG};
  logic [15:0] ini_d[5] = '{INIT_CFG0, INIT_USB_WIN, INIT_CFG_0WS, INIT_EVT_WIN, INIT_CFG_0WS};
  logic [15:0] cg_w[5]  = '{16'h8000, 16'h0185, 16'h0802, 16'h1001, 16'h1880};
  logic [15:0] cg_rb[5] = '{16'h8000, 16'h0185, 16'h0802, 16'h0801, 16'h1880};
  logic [14:0] cg_off[5] = '{15'h018f, 15'h0185, 15'h0002, 15'h0001, 15'h0080};
  logic [1:0]  cg_x[5]  = '{2'h0, 2'h0, 2'h1, 2'h1, 2'h3};

  xps_sfr_if sfr ();
  xps_ctl u_xps_ctl (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sfr(sfr.ctl));
  xps_dev u_xps_dev (.pclk(pclk), .presetn(presetn), .sfr(sfr.dev), .acc_valid(acc_valid),
    .acc_write(acc_write), .acc_addr(acc_addr), .int_cs(int_cs), .ext_cs_high(ext_cs_high),
    .ext_mirror(ext_mirror), .acc_wr_out(acc_wr_out), .acc_wide(acc_wide),
    .acc_demux(acc_demux), .acc_wait(acc_wait), .usb_enable(usb_enable),
    .evt_enable(evt_enable), .clk_off(clk_off), .xcvr_state(xcvr_state));
  xps_checker u_xps_checker (.pclk(pclk), .presetn(presetn), .req(sfr.req), .we(sfr.we),
    .addr(sfr.addr), .wdata(sfr.wdata), .rdata(sfr.rdata), .ack(sfr.ack));

  task automatic results;
    $display("compared %0d mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : results

  // one apb transfer, entered right after a rising edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    psel   <= 1'b1;
    pwrite <= wr;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    `CHK(pslverr, 1'b0)
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // controller command, wait for done, clear it, fetch last read
  task automatic sfr_op(input logic [2:0] cmd, input logic [15:0] a, input logic [15:0] d);
    logic [31:0] q;
    apb(1'b1, APB_ADDR, {16'h0000, a}, q);
    apb(1'b1, APB_WDATA, {16'h0000, d}, q);
    apb(1'b1, APB_CMD, {29'h0000_0000, cmd}, q);
    do apb(1'b0, APB_STATUS, 32'h0000_0000, q); while (q[STS_DONE] !== 1'b1);
    apb(1'b1, APB_STATUS, 32'h0000_0002, q);
    apb(1'b0, APB_RDATA, 32'h0000_0000, q);
    rd = q[15:0];
  endtask : sfr_op

  // one access on the peripheral bus, write or read per wr, decode checked next cycle
  task automatic acc(input logic [23:0] a, input logic [2:0] cs, input logic wr);
    acc_valid <= 1'b1;
    acc_write <= wr;
    acc_addr  <= a;
    @(posedge pclk);
    acc_valid <= 1'b0;
    #1;
    att = {ext_cs_high, ext_mirror, acc_wr_out, acc_wide, acc_demux, acc_wait};
    `CHK(int_cs, cs)
    @(posedge pclk);
  endtask : acc

  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 10000) begin
      mismatches++;
      results();
    end
  end

  initial begin
    {presetn, psel, penable, pwrite, acc_valid, acc_write} = 6'h00;
    {paddr, pwdata, acc_addr} = 68'h0;
    {mismatches, n_compared, cycles} = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK({int_cs, usb_enable, evt_enable, clk_off, xcvr_state}, 22'h00_0000)
    foreach (ofs[i]) begin
      sfr_op(3'h1, ofs[i], 16'h0000);
      `CHK(rd, RST_ZERO)
    end
    sfr_op(3'h4, 16'h0000, 16'h0000);
    foreach (ini_a[i]) begin
      sfr_op(3'h1, ini_a[i], 16'h0000);
      `CHK(rd, ini_d[i])
    end
    sfr_op(3'h3, OFS_SYS_CFG, 16'h0004);
    sfr_op(3'h3, OFS_PER_EN, 16'h00c0);
    `CHK({usb_enable, evt_enable}, 2'h3)
    acc(24'h0e_e123, 3'h2, 1'b1);
    `CHK(att, 9'h170)
    acc(24'h0e_d456, 3'h4, 1'b0);
    `CHK(att, 9'h130)
    acc(24'h12_3456, 3'h0, 1'b1);
    `CHK(att[8], 1'b0)
    sfr_op(3'h3, OFS_SYS_CFG, 16'h0006);
    acc(24'h0e_e000, 3'h2, 1'b1);
    `CHK(att[7], 1'b1)
    sfr_op(3'h3, OFS_USB_CFG, 16'h0440);
    acc(24'h0e_e000, 3'h2, 1'b1);
    `CHK(att[5:0], 6'h0f)
    foreach (cg_w[i]) begin
      sfr_op(3'h3, OFS_CLK_GATE, cg_w[i]);
      `CHK({clk_off, xcvr_state}, {cg_off[i], cg_x[i]})
      sfr_op(3'h1, OFS_CLK_GATE, 16'h0000);
      `CHK(rd, cg_rb[i])
    end
    `CHK(usb_enable, 1'b1)
    sfr_op(3'h3, OFS_PER_EN, 16'h0080);
    `CHK(usb_enable, 1'b0)
    acc(24'h0e_e000, 3'h0, 1'b1);
    sfr_op(3'h3, OFS_SYS_CFG, 16'h0000);
    `CHK(evt_enable, 1'b0)
    acc(24'h0e_d000, 3'h0, 1'b1);
    results();
  end
endmodule : internal_periph_bus_periph_setup_regs_bench
